// ==== mps_pkg.sv ====
// package: selection codes, widths and bit positions for the panel block
package mps_pkg;

  // ==========================================================
  // selection group
  localparam int SEL_N = 20;
  localparam int SEL_W = 5;
  localparam int DISP_W = 16;
  localparam int BANK_W = 2;

  // one-of-N selection indices, in lamp order
  localparam logic [SEL_W-1:0] SEL_OPERAND = 5'h00;
  localparam logic [SEL_W-1:0] SEL_PREADD = 5'h01;
  localparam logic [SEL_W-1:0] SEL_AUX1 = 5'h02;
  localparam logic [SEL_W-1:0] SEL_AUX2 = 5'h03;
  localparam logic [SEL_W-1:0] SEL_STAT = 5'h04;
  localparam logic [SEL_W-1:0] SEL_MODN = 5'h05;
  localparam logic [SEL_W-1:0] SEL_INTID = 5'h06;
  localparam logic [SEL_W-1:0] SEL_CMDV = 5'h07;
  localparam logic [SEL_W-1:0] SEL_IODI = 5'h08;
  localparam logic [SEL_W-1:0] SEL_IOPD = 5'h09;
  localparam logic [SEL_W-1:0] SEL_IOBUS = 5'h0a;
  localparam logic [SEL_W-1:0] SEL_TEST = 5'h0b;
  localparam logic [SEL_W-1:0] SEL_RHOLD = 5'h0c;
  localparam logic [SEL_W-1:0] SEL_SHOLD = 5'h0d;
  localparam logic [SEL_W-1:0] SEL_MADR = 5'h0e;
  localparam logic [SEL_W-1:0] SEL_MDAT = 5'h0f;
  localparam logic [SEL_W-1:0] SEL_RA = 5'h10;
  localparam logic [SEL_W-1:0] SEL_RB = 5'h11;
  localparam logic [SEL_W-1:0] SEL_RC = 5'h12;
  localparam logic [SEL_W-1:0] SEL_RD = 5'h13;

  // ==========================================================
  // reset values and field positions (lamp 0 is the msb)
  localparam logic [SEL_W-1:0] SEL_RST = SEL_MADR;
  localparam logic [DISP_W-1:0] DISP_RST = 16'h0000;
  localparam int MOD_LO_POS = 5;
  localparam int CPU_ONE_POS = 13;
  localparam int DEV_LO_POS = 8;
  localparam logic [1:0] DIV_TERM = 2'h3;

  typedef enum logic [1:0] {
    MPS_ST_IDLE = 2'b00,
    MPS_ST_RUN = 2'b01,
    MPS_ST_WAIT = 2'b10
  } mps_step_st_t;

endpackage

// ==== mps_step_sync.sv ====
// two-flop synchroniser plus rising-edge detector for the step switch
module mps_step_sync
  import mps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // raw switch and pulse
  input wire logic raw_in,
  output logic level_out,
  output logic rise_pulse
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // crossing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // one pulse per press, however long held
  assign rise_pulse = s2_q & ~s3_q;
  assign level_out = s2_q;

endmodule

// ==== mps_sel_cell.sv ====
// one selection lamp cell: lights on its own push, dark on any other
module mps_sel_cell
  import mps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pushes
  input wire logic own_push,
  input wire logic any_push,
  input wire logic rst_val,
  // lamp
  output logic lamp_q
);

  logic lamp_d;

  // any other push clears this lamp, keeping the group one-hot
  assign lamp_d = any_push ? own_push : lamp_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_q <= 1'b0;
    end else begin
      lamp_q <= lamp_d;
    end
  end

  logic unused_rst;
  assign unused_rst = rst_val;

endmodule

// ==== mps_panel.sv ====
// maintenance panel: cycle gating, source selection, lamp display, loads
module mps_panel
  import mps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // operator switches, asynchronous
  input wire logic clk_inhibit_sw,
  input wire logic step_sw,
  input wire logic [SEL_N-1:0] sel_up_sw,
  input wire logic [SEL_N-1:0] sel_dn_sw,
  input wire logic alt_source_sw,
  input wire logic load_from_switches_sw,
  input wire logic load_from_display_sw,
  input wire logic mem_panel_op_sw,
  input wire logic [DISP_W-1:0] operator_word_switches,
  // processor sources, same clock
  input wire logic [DISP_W-1:0] operand_view,
  input wire logic [DISP_W-1:0] preadder_view,
  input wire logic [DISP_W-1:0] aux_index_one_view,
  input wire logic [DISP_W-1:0] aux_index_two_view,
  input wire logic [DISP_W-1:0] status_view,
  input wire logic [2:0] module_number_view,
  input wire logic cpu_is_one,
  input wire logic [DISP_W-1:0] interrupt_identity_view,
  input wire logic [2:0] io_command,
  input wire logic [7:0] io_device_number,
  input wire logic [DISP_W-1:0] source_bus,
  input wire logic [DISP_W-1:0] io_processor_data_in_view,
  input wire logic [DISP_W-1:0] io_data_bus_n,
  input wire logic [DISP_W-1:0] test_connector,
  input wire logic [DISP_W-1:0] r_bus_holding_view,
  input wire logic [DISP_W-1:0] s_bus_holding_view,
  input wire logic [DISP_W-1:0] scratch_pad_zero,
  input wire logic [BANK_W-1:0] absolute_bank_register,
  input wire logic [DISP_W-1:0] scratch_pad_one,
  input wire logic [DISP_W-1:0] stack_ra,
  input wire logic [DISP_W-1:0] stack_rb,
  input wire logic [DISP_W-1:0] stack_rc,
  input wire logic [DISP_W-1:0] stack_rd,
  // cycle control
  output logic cycle_enable,
  // lamps
  output logic [SEL_N-1:0] source_pick_lamps,
  output logic [DISP_W-1:0] display_lamps,
  output logic [BANK_W-1:0] bank_lamps,
  // load port
  output logic load_strobe,
  output logic [SEL_W-1:0] load_target,
  output logic [DISP_W-1:0] load_data,
  output logic mem_addr_hold
);

  // ==========================================================
  // switch synchronisers
  logic inh_s1_q, inh_s2_q;
  logic alt_s1_q, alt_s2_q;
  logic mem_s1_q, mem_s2_q;
  logic lsw_s1_q, lsw_s2_q, lsw_s3_q;
  logic ldp_s1_q, ldp_s2_q, ldp_s3_q;
  logic [SEL_N-1:0] up_s1_q, up_s2_q, up_s3_q;
  logic [SEL_N-1:0] dn_s1_q, dn_s2_q, dn_s3_q;
  logic [DISP_W-1:0] wsw_s1_q, wsw_s2_q;
  logic step_level;
  logic step_pulse;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {inh_s1_q, inh_s2_q, alt_s1_q, alt_s2_q} <= 4'h0;
      {mem_s1_q, mem_s2_q} <= 2'h0;
      {lsw_s1_q, lsw_s2_q, lsw_s3_q} <= 3'h0;
      {ldp_s1_q, ldp_s2_q, ldp_s3_q} <= 3'h0;
    end else begin
      inh_s1_q <= clk_inhibit_sw;
      inh_s2_q <= inh_s1_q;
      alt_s1_q <= alt_source_sw;
      alt_s2_q <= alt_s1_q;
      mem_s1_q <= mem_panel_op_sw;
      mem_s2_q <= mem_s1_q;
      lsw_s1_q <= load_from_switches_sw;
      lsw_s2_q <= lsw_s1_q;
      lsw_s3_q <= lsw_s2_q;
      ldp_s1_q <= load_from_display_sw;
      ldp_s2_q <= ldp_s1_q;
      ldp_s3_q <= ldp_s2_q;
    end
  end

  // selector pushes keep a third stage for their edge detectors
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      up_s1_q <= '0;
      up_s2_q <= '0;
      up_s3_q <= '0;
      dn_s1_q <= '0;
      dn_s2_q <= '0;
      dn_s3_q <= '0;
    end else begin
      up_s1_q <= sel_up_sw;
      up_s2_q <= up_s1_q;
      up_s3_q <= up_s2_q;
      dn_s1_q <= sel_dn_sw;
      dn_s2_q <= dn_s1_q;
      dn_s3_q <= dn_s2_q;
    end
  end

  // word switches only feed load data, so two stages suffice
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wsw_s1_q <= DISP_RST;
      wsw_s2_q <= DISP_RST;
    end else begin
      wsw_s1_q <= operator_word_switches;
      wsw_s2_q <= wsw_s1_q;
    end
  end

  mps_step_sync u_step (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw_in(step_sw),
    .level_out(step_level),
    .rise_pulse(step_pulse)
  );

  // ==========================================================
  // cycle gating: divide by four, single step under inhibit
  logic [1:0] div_q, div_d;
  logic div_term;
  mps_step_st_t st_q, st_d;

  assign div_term = (div_q == DIV_TERM);
  assign div_d = div_q + 2'h1;

  always_comb begin
    st_d = st_q;
    case (st_q)
      MPS_ST_IDLE: begin
        if (!inh_s2_q) begin
          st_d = MPS_ST_RUN;
        end else if (step_pulse) begin
          st_d = MPS_ST_WAIT;
        end
      end
      MPS_ST_RUN: begin
        if (inh_s2_q && div_term) begin
          st_d = MPS_ST_IDLE;
        end
      end
      MPS_ST_WAIT: begin
        if (div_term) begin
          st_d = inh_s2_q ? MPS_ST_IDLE : MPS_ST_RUN;
        end
      end
      default: begin
        st_d = MPS_ST_IDLE;
      end
    endcase
  end

  // one machine cycle ends on each divide-by-four terminal count in run or wait
  assign cycle_enable = div_term &&
    ((st_q == MPS_ST_RUN) || (st_q == MPS_ST_WAIT));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 2'h0;
      st_q <= MPS_ST_IDLE;
    end else begin
      div_q <= div_d;
      st_q <= st_d;
    end
  end

  // ==========================================================
  // one-hot selection group
  logic [SEL_N-1:0] push;
  logic [SEL_N-1:0] push_below;
  logic [SEL_N-1:0] push_win;
  logic any_push;
  logic [SEL_N-1:0] sel_rst;

  // a push lights the lamp above (up) of index i, below (down) of i+1
  genvar gi;
  generate
    for (gi = 0; gi < SEL_N; gi++) begin : g_sel
      logic up_edge;
      logic dn_edge;
      assign up_edge = up_s2_q[gi] & ~up_s3_q[gi];
      if (gi == 0) begin : g_first
        assign dn_edge = 1'b0;
        assign push_below[gi] = 1'b0;
      end else begin : g_rest
        assign dn_edge = dn_s2_q[gi-1] & ~dn_s3_q[gi-1];
        assign push_below[gi] = push_below[gi-1] | push[gi-1];
      end
      assign push[gi] = up_edge | dn_edge;
      assign push_win[gi] = push[gi] & ~push_below[gi];
      assign sel_rst[gi] = (gi == int'(SEL_RST));
      mps_sel_cell u_cell (
        .mclk(mclk),
        .reset_n(reset_n),
        .own_push(push_win[gi]),
        .any_push(any_push),
        .rst_val(sel_rst[gi]),
        .lamp_q(source_pick_lamps[gi])
      );
    end
  endgenerate

  // simultaneous pushes: only the lowest pushed lamp lights, one-hot holds
  assign any_push = |push;

  logic [SEL_W-1:0] sel_idx;
  always_comb begin
    sel_idx = SEL_RST;
    for (int i = SEL_N - 1; i >= 0; i--) begin
      if (source_pick_lamps[i]) begin
        sel_idx = SEL_W'(i);
      end
    end
  end

  // ==========================================================
  // display mux; lamp 0 is the msb of the word
  logic [DISP_W-1:0] disp_d, disp_q;
  logic [BANK_W-1:0] bank_d, bank_q;
  logic [DISP_W-1:0] mod_word, cmd_word;

  // bit for lamp p sits at DISP_W-1-p
  assign mod_word = (DISP_W'(module_number_view) << (DISP_W-3-MOD_LO_POS)) |
    (DISP_W'(cpu_is_one) << (DISP_W-1-CPU_ONE_POS));
  assign cmd_word = (DISP_W'(io_command) << (DISP_W-DEV_LO_POS)) |
    DISP_W'(io_device_number);

  always_comb begin
    bank_d = '0;
    case (sel_idx)
      SEL_OPERAND: disp_d = operand_view;
      SEL_PREADD: disp_d = preadder_view;
      SEL_AUX1: disp_d = aux_index_one_view;
      SEL_AUX2: disp_d = aux_index_two_view;
      SEL_STAT: disp_d = status_view;
      SEL_MODN: disp_d = mod_word;
      SEL_INTID: disp_d = interrupt_identity_view;
      SEL_CMDV: disp_d = cmd_word;
      SEL_IODI: disp_d = source_bus;
      SEL_IOPD: disp_d = io_processor_data_in_view;
      SEL_IOBUS: disp_d = ~io_data_bus_n;
      SEL_TEST: disp_d = test_connector;
      SEL_RHOLD: disp_d = r_bus_holding_view;
      SEL_SHOLD: disp_d = s_bus_holding_view;
      SEL_MADR: begin
        disp_d = scratch_pad_zero;
        bank_d = absolute_bank_register;
      end
      SEL_MDAT: disp_d = scratch_pad_one;
      SEL_RA: disp_d = stack_ra;
      SEL_RB: disp_d = stack_rb;
      SEL_RC: disp_d = stack_rc;
      SEL_RD: disp_d = stack_rd;
      default: disp_d = DISP_RST;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      disp_q <= DISP_RST;
      bank_q <= '0;
    end else begin
      disp_q <= disp_d;
      bank_q <= bank_d;
    end
  end

  assign display_lamps = disp_q;
  assign bank_lamps = bank_q;

  // ==========================================================
  // load register operations
  logic lsw_pulse, ldp_pulse;
  logic sel_loadable, stack_or_pad_one, store_ok;
  logic load_d, load_q;
  logic [DISP_W-1:0] ldata_d, ldata_q;
  logic [SEL_W-1:0] ltgt_q;

  assign lsw_pulse = lsw_s2_q & ~lsw_s3_q;
  assign ldp_pulse = ldp_s2_q & ~ldp_s3_q;
  // switch-loadable: memory views and the four stack registers only
  assign sel_loadable = (sel_idx >= SEL_MADR);
  assign stack_or_pad_one = (sel_idx >= SEL_RA) || (sel_idx == SEL_MDAT);
  // alt source shows other copies, so writing would hit the wrong one
  assign store_ok = !(stack_or_pad_one && alt_s2_q);
  assign load_d = store_ok &&
    ((lsw_pulse && sel_loadable) || ldp_pulse);
  assign ldata_d = lsw_pulse ? wsw_s2_q : disp_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_q <= 1'b0;
      ldata_q <= DISP_RST;
      ltgt_q <= SEL_RST;
    end else begin
      load_q <= load_d;
      ldata_q <= ldata_d;
      ltgt_q <= sel_idx;
    end
  end

  assign load_strobe = load_q;
  assign load_data = ldata_q;
  assign load_target = ltgt_q;
  // panel memory ops route their address through scratch pad zero
  assign mem_addr_hold = mem_s2_q;

  logic unused_lvl;
  assign unused_lvl = step_level;

endmodule

// ==== mps_panel_checker.sv ====
// port checker for the maintenance panel block, bound to its top module
module mps_panel_checker
  import mps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // switches and sources
  input wire logic clk_inhibit_sw,
  input wire logic step_sw,
  input wire logic [SEL_N-1:0] sel_up_sw,
  input wire logic [SEL_N-1:0] sel_dn_sw,
  input wire logic [2:0] io_command,
  input wire logic [7:0] io_device_number,
  input wire logic [DISP_W-1:0] io_data_bus_n,
  input wire logic [DISP_W-1:0] test_connector,
  // outputs
  input wire logic cycle_enable,
  input wire logic [SEL_N-1:0] source_pick_lamps,
  input wire logic [DISP_W-1:0] display_lamps,
  input wire logic [BANK_W-1:0] bank_lamps
);
  timeunit 1ns;
  timeprecision 1ns;
  logic step_q;
  logic [3:0] quiet_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ====
  // cycles since a press while inhibited
  // a stepped cycle lags its press by sync plus divider alignment
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      step_q <= step_sw;
      if (!clk_inhibit_sw || (step_sw && !step_q)) begin
        quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
        quiet_q <= quiet_q + 4'h1;
      end
    end
  end
  // ====
  // properties
  sequence s_run_span;
    (cycle_enable && !clk_inhibit_sw) ##1 !clk_inhibit_sw [*3];
  endsequence
  sequence s_lone_up;
    $onehot(sel_up_sw) && $past(sel_up_sw) == '0 && sel_dn_sw == '0;
  endsequence
  property p_run_rate;
    s_run_span |=> cycle_enable;
  endproperty
  property p_gap;
    cycle_enable |=> !cycle_enable [*3];
  endproperty
  property p_step_cause;
    cycle_enable |-> quiet_q < 4'hc;
  endproperty
  property p_one_lit;
    $onehot0(source_pick_lamps);
  endproperty
  property p_pick;
    s_lone_up |-> ##[1:4] source_pick_lamps == sel_up_sw;
  endproperty
  property p_test_src;
    source_pick_lamps[SEL_TEST] |=> display_lamps == $past(test_connector);
  endproperty
  property p_bus_true;
    source_pick_lamps[SEL_IOBUS] |=> display_lamps == ~$past(io_data_bus_n);
  endproperty
  property p_cmd_dev;
    source_pick_lamps[SEL_CMDV] |=>
      display_lamps == {5'h00, $past(io_command), $past(io_device_number)};
  endproperty
  property p_bank_dark;
    source_pick_lamps != '0 && !source_pick_lamps[SEL_MADR] |=>
      bank_lamps == '0;
  endproperty
  a_run_rate: assert property (p_run_rate)
    else $error("free run rate off");
  a_gap: assert property (p_gap)
    else $error("cycles closer than four clocks");
  a_step_cause: assert property (p_step_cause)
    else $error("cycle without a press");
  a_one_lit: assert property (p_one_lit)
    else $error("more than one lamp lit");
  a_pick: assert property (p_pick)
    else $error("pushed lamp not lit alone");
  a_test_src: assert property (p_test_src)
    else $error("test view wrong");
  a_bus_true: assert property (p_bus_true)
    else $error("bus view not inverted");
  a_cmd_dev: assert property (p_cmd_dev)
    else $error("command view wrong");
  a_bank_dark: assert property (p_bank_dark)
    else $error("bank lamps lit");
endmodule

bind mps_panel mps_panel_checker i_mps_panel_checker (
  .mclk(mclk), .reset_n(reset_n), .clk_inhibit_sw(clk_inhibit_sw),
  .step_sw(step_sw), .sel_up_sw(sel_up_sw), .sel_dn_sw(sel_dn_sw),
  .io_command(io_command), .io_device_number(io_device_number),
  .io_data_bus_n(io_data_bus_n), .test_connector(test_connector),
  .cycle_enable(cycle_enable), .source_pick_lamps(source_pick_lamps),
  .display_lamps(display_lamps), .bank_lamps(bank_lamps)
);

// ==== mps_core_model.sv ====
// processor core stand-in: register views that advance per machine cycle
module mps_core_model
  import mps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // machine cycle
  input wire logic cycle_enable,
  // register views
  output logic [DISP_W-1:0] src [SEL_N],
  output logic [DISP_W-1:0] cycle_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // views move only on enabled cycles, so a stopped clock freezes them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_count <= 16'h0000;
    end else if (cycle_enable) begin
      cycle_count <= cycle_count + 16'h0001;
    end
  end
  for (genvar i = 0; i < SEL_N; i++) begin : g_src
    assign src[i] = 16'h9c00 ^ 16'(i * 16'h0111) ^ cycle_count;
  end
endmodule

// ==== mps_panel_test.sv ====
// self-checking bench for the maintenance panel block
module mps_panel_test
  import mps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, inh, step, alt, lds, ldd, mop;
  logic [SEL_N-1:0] up, dn;
  logic [DISP_W-1:0] wsw, mcnt, ld_cap;
  logic [DISP_W-1:0] src [SEL_N];
  logic [SEL_W-1:0] lt_cap;
  wire ce, ls, mh;
  wire [SEL_N-1:0] lamps;
  wire [DISP_W-1:0] disp, ld;
  wire [BANK_W-1:0] bank;
  wire [SEL_W-1:0] lt;
  wire [BANK_W-1:0] abank = ~mcnt[1:0];
  int n_fail = 0;
  int cmp_count = 0;
  int n_ce = 0;
  int n_ls = 0;

  mps_core_model i_mps_core_model (
    .mclk(mclk), .reset_n(reset_n), .cycle_enable(ce), .src(src),
    .cycle_count(mcnt)
  );
  mps_panel i_mps_panel (
    .mclk(mclk), .reset_n(reset_n), .clk_inhibit_sw(inh), .step_sw(step),
    .sel_up_sw(up), .sel_dn_sw(dn), .alt_source_sw(alt),
    .load_from_switches_sw(lds), .load_from_display_sw(ldd),
    .mem_panel_op_sw(mop), .operator_word_switches(wsw),
    .operand_view(src[0]), .preadder_view(src[1]),
    .aux_index_one_view(src[2]), .aux_index_two_view(src[3]),
    .status_view(src[4]), .module_number_view(src[5][2:0]),
    .cpu_is_one(src[5][4]), .interrupt_identity_view(src[6]),
    .io_command(src[7][10:8]), .io_device_number(src[7][7:0]),
    .source_bus(src[8]), .io_processor_data_in_view(src[9]),
    .io_data_bus_n(src[10]), .test_connector(src[11]),
    .r_bus_holding_view(src[12]), .s_bus_holding_view(src[13]),
    .scratch_pad_zero(src[14]), .absolute_bank_register(abank),
    .scratch_pad_one(src[15]), .stack_ra(src[16]), .stack_rb(src[17]),
    .stack_rc(src[18]), .stack_rd(src[19]), .cycle_enable(ce),
    .source_pick_lamps(lamps), .display_lamps(disp), .bank_lamps(bank),
    .load_strobe(ls), .load_target(lt), .load_data(ld), .mem_addr_hold(mh)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ====
  // monitors sample mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    if (ce === 1'b1) n_ce++;
    if (ls === 1'b1) begin
      n_ls++;
      lt_cap = lt;
      ld_cap = ld;
    end
  end
  // ====
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic push(input int k);
    @(posedge mclk);
    up[k] <= 1'b1;
    tick(6);
    up[k] <= 1'b0;
    tick(4);
  endtask
  function automatic logic [15:0] exp_disp(input int k);
    case (k)
      5: return {5'h00, src[5][2:0], 5'h00, src[5][4], 2'h0};
      7: return {5'h00, src[7][10:8], src[7][7:0]};
      10: return ~src[10];
      default: return src[k];
    endcase
  endfunction
  task automatic load(input int k, input bit sw, input int n,
                      input logic [15:0] d);
    int c0;
    push(k);
    c0 = n_ls;
    @(posedge mclk);
    lds <= sw;
    ldd <= !sw;
    tick(8);
    lds <= 1'b0;
    ldd <= 1'b0;
    tick(2);
    chk(n_ls - c0, n);
    if (n > 0) begin
      chk(lt_cap, k);
      chk(ld_cap, d);
    end
  endtask
  // ====
  // scenarios
  task automatic t_select;
    for (int k = 0; k < SEL_N; k++) begin
      push(k);
      chk(lamps, 32'h1 << k);
      chk(disp, exp_disp(k));
      chk(bank, (k == 14) ? abank : 2'h0);
    end
    @(posedge mclk);
    dn[3] <= 1'b1;
    tick(6);
    dn[3] <= 1'b0;
    tick(4);
    chk(lamps, 32'h10);
    @(posedge mclk);
    up[2] <= 1'b1;
    up[6] <= 1'b1;
    tick(6);
    up <= '0;
    tick(4);
    chk(lamps, 32'h4);
  endtask
  task automatic t_step;
    int c0;
    c0 = n_ce;
    @(posedge mclk);
    step <= 1'b1;
    tick(30);
    chk(n_ce - c0, 1);
    step <= 1'b0;
    inh <= 1'b0;
    tick(10);
    c0 = n_ce;
    step <= 1'b1;
    tick(40);
    chk(n_ce - c0, 10);
    inh <= 1'b1;
    tick(10);
    c0 = n_ce;
    tick(30);
    chk(n_ce - c0, 0);
    step <= 1'b0;
  endtask
  task automatic t_load;
    load(5, 1'b1, 0, 16'h0000);
    load(13, 1'b1, 0, 16'h0000);
    load(16, 1'b1, 1, wsw);
    alt <= 1'b1;
    load(19, 1'b1, 0, 16'h0000);
    load(15, 1'b0, 0, 16'h0000);
    alt <= 1'b0;
    load(3, 1'b0, 1, src[3]);
    load(15, 1'b1, 1, wsw);
  endtask
  task automatic t_mem;
    @(posedge mclk);
    mop <= 1'b1;
    tick(4);
    chk(mh, 1);
    mop <= 1'b0;
    tick(4);
    chk(mh, 0);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    reset_n = 1'b0;
    inh = 1'b1;
    {step, alt, lds, ldd, mop} = 5'h00;
    up = '0;
    dn = '0;
    wsw = 16'h3c5a;
    tick(2);
    reset_n <= 1'b1;
    tick(4);
    chk(lamps, 0);
    t_select();
    t_step();
    t_load();
    t_mem();
    print_verdict();
  end
  initial begin
    tick(5000);
    n_fail++;
    print_verdict();
  end
endmodule
